// ---- rtl/fde_engine.sv ----
// frame dma engine: extraction channel 0, injection channel 1, ahb-lite registers
// Behaviour
// - a buffer holds at most one frame; frames may span buffers
// - frame bytes go to consecutive byte addresses in arrival order
// - offset given both ways; length given for injection, computed for extraction
// - word 0 next pointer, word 1 buffer pointer, both word-aligned
// - word 2 low half is buffer size; top byte is never written
// - status word: offset in bits 31..20, byte count in bits 15..0
// - status bit 16 marks start of frame, bit 17 end of frame
// - bit 18 abort: set on aborted extraction, aborts injection when loaded set
// - bit 19 pruned on extraction, done on injection; loaded set means abort
// - size-word bit 16 on load bumps the signal counter
// - size-word bit 17 on injection consumes a token, waiting while zero; a block loaded with abort or done set skips the token
// - write next pointer, then activate; engine fetches and transfers
// - disable request lets the current block finish and write status first
// - per-channel state disabled, updating or active, readable, disabled at reset
// - null next pointer at update time disables the channel
// - null-pointer event: extraction on load, injection on status write
// - activate cancels a pending disable or restarts a stopped channel
// - current block address readable; never refetched on reactivation
// - stop-after-frame and stop-after-block disable and raise the null event
// - frame counter on non-aborted end-of-frame status; block counter per fetch
// - extraction status rewrites flags and count, offset as loaded
// - injection status only sets the done flag
//
// Decided for this implementation: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module fde_engine
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output fde_pkg::fde_mem_t mem,
	input wire logic mem_ack,
	input wire logic [31:0] mem_rdata,
	input wire logic xq_valid,
	input fde_pkg::fde_xbeat_t xq_beat,
	output logic xq_ready,
	output logic iq_valid,
	output fde_pkg::fde_ibeat_t iq_beat,
	input wire logic iq_ready
);

	////////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		fde_pkg::fde_chan_t [1:0] ch;
		logic [7:0] tokens;
		fde_pkg::fde_eng_t eng;
		logic sel;
		logic [1:0] widx;
		logic [31:0] next_block_pointer;
		logic [31:0] bufp;
		logic [17:0] size;
		logic [31:0] stat;
		logic [15:0] cnt;
		logic sof;
		logic eof;
		logic abort;
		logic pd;
		fde_pkg::fde_mem_t mem;
		logic xq_ready;
		logic iq_valid;
		fde_pkg::fde_ibeat_t iq;
		logic ap_valid;
		logic ap_write;
		logic [7:0] ap_addr;
		logic [31:0] hrdata;
		logic hreadyout;
	} fde_state_t;

	fde_state_t s;
	fde_state_t n;

	////////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [3:0] lane_be(input logic [31:0] a);
		lane_be = 4'h1 << a[1:0];
	endfunction : lane_be

	function automatic logic [7:0] lane_byte(input logic [31:0] w, input logic [31:0] a);
		lane_byte = w[{a[1:0], 3'h0} +: 8];
	endfunction : lane_byte

	// offset plus count still inside the buffer
	function automatic logic in_room(input logic [31:0] st, input logic [15:0] c,
		input logic [17:0] sz);
		in_room = ({5'h00, st[31:fde_pkg::ST_OFS_LO]} + {1'b0, c}) < {1'b0, sz[15:0]};
	endfunction : in_room

	function automatic logic [31:0] byte_addr(input fde_state_t q);
		byte_addr = q.bufp + {20'h00000, q.stat[31:fde_pkg::ST_OFS_LO]} + {16'h0000, q.cnt};
	endfunction : byte_addr

	function automatic logic safe_of(input fde_pkg::fde_chan_t c);
		safe_of = (c.st == fde_pkg::CH_DIS) || (c.dis_req && c.st == fde_pkg::CH_ACT);
	endfunction : safe_of

	function automatic logic [31:0] rd_reg(input fde_state_t q, input logic [7:0] a);
		case (a)
			fde_pkg::A_DISABLE: rd_reg = {30'h0, q.ch[1].dis_req, q.ch[0].dis_req};
			fde_pkg::A_STATE: rd_reg = {28'h0, q.ch[1].st, q.ch[0].st};
			fde_pkg::A_SAFE: rd_reg = {30'h0, safe_of(q.ch[1]), safe_of(q.ch[0])};
			fde_pkg::A_NULL_EVT: rd_reg = {30'h0, q.ch[1].null_evt, q.ch[0].null_evt};
			fde_pkg::A_CFG: rd_reg = {28'h0, q.ch[1].stop_blk, q.ch[1].stop_frm,
				q.ch[0].stop_blk, q.ch[0].stop_frm};
			fde_pkg::A_NEXT0: rd_reg = q.ch[0].next_ptr;
			fde_pkg::A_NEXT1: rd_reg = q.ch[1].next_ptr;
			fde_pkg::A_CUR0: rd_reg = q.ch[0].cur_ptr;
			fde_pkg::A_CUR1: rd_reg = q.ch[1].cur_ptr;
			fde_pkg::A_CNT0: rd_reg = {8'h00, q.ch[0].frm_cnt, q.ch[0].blk_cnt, q.ch[0].sig_cnt};
			fde_pkg::A_CNT1: rd_reg = {8'h00, q.ch[1].frm_cnt, q.ch[1].blk_cnt, q.ch[1].sig_cnt};
			fde_pkg::A_TOKEN: rd_reg = {24'h000000, q.tokens};
			default: rd_reg = 32'h00000000;
		endcase
	endfunction : rd_reg

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb
	begin
		logic [1:0] act;
		logic [1:0] dis;
		logic [1:0] clr;
		logic [1:0] set_evt;
		logic c;
		logic stop;
		logic frm_end;
		logic [31:0] ba;
		act = 2'b00;
		ba = byte_addr(s);
		dis = 2'b00;
		clr = 2'b00;
		set_evt = 2'b00;
		c = s.sel;
		stop = 1'b0;
		frm_end = 1'b0;
		n = s;

		// ahb-lite: zero wait states, read data fetched in the address phase
		n.hreadyout = 1'b1;
		n.ap_valid = hsel && htrans[1] && hready;
		n.ap_write = hwrite;
		n.ap_addr = haddr[7:0];
		if (hsel && htrans[1] && hready && !hwrite)
		begin
			n.hrdata = rd_reg(s, haddr[7:0]);
		end

		if (s.ap_valid && s.ap_write)
		begin
			case (s.ap_addr)
				fde_pkg::A_ACTIVATE: act = hwdata[1:0];
				fde_pkg::A_DISABLE: dis = hwdata[1:0];
				fde_pkg::A_NULL_EVT: clr = hwdata[1:0];
				fde_pkg::A_CFG:
				begin
					n.ch[0].stop_frm = hwdata[fde_pkg::CFG_STOP_FRM];
					n.ch[0].stop_blk = hwdata[fde_pkg::CFG_STOP_BLK];
					n.ch[1].stop_frm = hwdata[fde_pkg::CFG_STRIDE + fde_pkg::CFG_STOP_FRM];
					n.ch[1].stop_blk = hwdata[fde_pkg::CFG_STRIDE + fde_pkg::CFG_STOP_BLK];
				end
				fde_pkg::A_NEXT0: n.ch[0].next_ptr = hwdata;
				fde_pkg::A_NEXT1: n.ch[1].next_ptr = hwdata;
				fde_pkg::A_TOKEN: n.tokens = hwdata[7:0];
				default: ;
			endcase
		end

		////////////////////////////////////////////////////////////////////////////////
		// channel engine: serves one block of one channel at a time
		case (s.eng)
			fde_pkg::E_IDLE:
			begin
				// higher channel number wins
				c = (s.ch[1].st == fde_pkg::CH_UPD);
				if (s.ch[c].st == fde_pkg::CH_UPD)
				begin
					if (s.ch[c].dis_req || s.ch[c].next_ptr == fde_pkg::RST_PTR)
					begin
						n.ch[c].st = fde_pkg::CH_DIS;
						n.ch[c].dis_req = 1'b0;
					end
					else
					begin
						n.sel = c;
						n.ch[c].cur_ptr = s.ch[c].next_ptr;
						n.ch[c].blk_cnt = s.ch[c].blk_cnt + 8'h01;
						n.widx = 2'h0;
						n.mem = '{req: 1'b1, we: 1'b0, addr: s.ch[c].next_ptr,
							wdata: 32'h0, be: 4'hf};
						n.eng = fde_pkg::E_LOAD;
					end
				end
			end
			fde_pkg::E_LOAD:
			begin
				if (mem_ack)
				begin
					case (s.widx)
						2'h0: n.next_block_pointer = mem_rdata;
						2'h1: n.bufp = mem_rdata;
						2'h2: n.size = mem_rdata[17:0];
						default: n.stat = mem_rdata;
					endcase
					n.widx = s.widx + 2'h1;
					n.mem.addr = s.mem.addr + fde_pkg::WORD_STEP;
					if (s.widx == 2'h3)
					begin
						n.mem.req = 1'b0;
						// current block never refetched; its link becomes the next load
						n.ch[c].next_ptr = s.next_block_pointer;
						if (s.size[fde_pkg::SZ_SIG])
						begin
							n.ch[c].sig_cnt = s.ch[c].sig_cnt + 8'h01;
						end
						set_evt[c] = !c && s.next_block_pointer == fde_pkg::RST_PTR;
						n.ch[c].st = fde_pkg::CH_ACT;
						n.cnt = 16'h0000;
						n.sof = 1'b0;
						n.eof = 1'b0;
						n.pd = 1'b0;
						n.abort = c && (mem_rdata[fde_pkg::ST_ABORT] || mem_rdata[fde_pkg::ST_PD]);
						if (!c)
						begin
							n.eng = fde_pkg::E_XTAKE;
						end
						else if (s.size[fde_pkg::SZ_TOKEN] && !n.abort)
						begin
							n.eng = fde_pkg::E_TOKEN;
						end
						else
						begin
							n.eng = fde_pkg::E_INEXT;
						end
					end
				end
			end
			fde_pkg::E_TOKEN:
			begin
				if (n.tokens != 8'h00)
				begin
					n.tokens = n.tokens - 8'h01;
					n.eng = fde_pkg::E_INEXT;
				end
			end
			fde_pkg::E_XTAKE:
			begin
				if (!in_room(s.stat, s.cnt, s.size))
				begin
					n.xq_ready = 1'b0;
					n.eng = fde_pkg::E_STATUS;
				end
				else if (s.xq_ready && xq_valid)
				begin
					n.xq_ready = 1'b0;
					n.sof = s.sof || (s.cnt == 16'h0000 && xq_beat.sof);
					n.eof = xq_beat.eof;
					n.abort = xq_beat.abort;
					n.pd = xq_beat.pruned;
					// one byte per write, lane chosen by byte address
					n.mem = '{req: 1'b1, we: 1'b1, addr: {ba[31:2], 2'b00},
						wdata: {4{xq_beat.data}}, be: lane_be(ba)};
					n.eng = fde_pkg::E_XWRITE;
				end
				else
				begin
					n.xq_ready = 1'b1;
				end
			end
			fde_pkg::E_XWRITE:
			begin
				if (mem_ack)
				begin
					n.mem.req = 1'b0;
					n.cnt = s.cnt + 16'h0001;
					// a buffer never holds bytes of two frames
					n.eng = (s.eof || s.abort) ? fde_pkg::E_STATUS : fde_pkg::E_XTAKE;
				end
			end
			fde_pkg::E_INEXT:
			begin
				if (s.abort)
				begin
					n.iq_valid = 1'b1;
					n.iq = '{data: 8'h00, sof: s.stat[fde_pkg::ST_SOF], eof: 1'b1, abort: 1'b1};
					n.eng = fde_pkg::E_IPUSH;
				end
				else if (s.cnt == s.stat[15:0] || !in_room(s.stat, s.cnt, s.size))
				begin
					n.eng = fde_pkg::E_STATUS;
				end
				else
				begin
					n.mem = '{req: 1'b1, we: 1'b0, addr: {ba[31:2], 2'b00},
						wdata: 32'h0, be: 4'hf};
					n.eng = fde_pkg::E_IREAD;
				end
			end
			fde_pkg::E_IREAD:
			begin
				if (mem_ack)
				begin
					n.mem.req = 1'b0;
					n.iq_valid = 1'b1;
					n.iq = '{data: lane_byte(mem_rdata, byte_addr(s)),
						sof: s.stat[fde_pkg::ST_SOF] && s.cnt == 16'h0000,
						eof: s.stat[fde_pkg::ST_EOF] && s.cnt == s.stat[15:0] - 16'h0001,
						abort: 1'b0};
					n.eng = fde_pkg::E_IPUSH;
				end
			end
			fde_pkg::E_IPUSH:
			begin
				if (iq_ready)
				begin
					n.iq_valid = 1'b0;
					n.cnt = s.cnt + 16'h0001;
					n.eng = s.iq.abort ? fde_pkg::E_STATUS : fde_pkg::E_INEXT;
				end
			end
			fde_pkg::E_STATUS:
			begin
				if (!s.mem.req)
				begin
					n.ch[c].st = fde_pkg::CH_UPD;
					n.mem.req = 1'b1;
					n.mem.we = 1'b1;
					n.mem.be = 4'hf;
					n.mem.addr = s.ch[c].cur_ptr + fde_pkg::STAT_OFS;
					if (!c)
					begin
						n.mem.wdata = {s.stat[31:fde_pkg::ST_OFS_LO], s.pd, s.abort, s.eof,
							s.sof, s.cnt};
					end
					else
					begin
						n.mem.wdata = s.stat | (32'h1 << fde_pkg::ST_PD);
					end
				end
				else if (mem_ack)
				begin
					n.mem.req = 1'b0;
					frm_end = c ? s.stat[fde_pkg::ST_EOF] : s.eof;
					if (frm_end && !s.abort)
					begin
						n.ch[c].frm_cnt = s.ch[c].frm_cnt + 8'h01;
					end
					stop = (s.ch[c].stop_frm && frm_end) || s.ch[c].stop_blk;
					set_evt[c] = stop || (c && s.next_block_pointer == fde_pkg::RST_PTR);
					if (stop || s.ch[c].dis_req)
					begin
						n.ch[c].st = fde_pkg::CH_DIS;
						n.ch[c].dis_req = 1'b0;
					end
					n.eng = fde_pkg::E_IDLE;
				end
			end
			default: n.eng = fde_pkg::E_IDLE;
		endcase

		////////////////////////////////////////////////////////////////////////////////
		// software requests and sticky events
		for (int i = 0; i < 2; i++)
		begin
			if (dis[i] && n.ch[i].st != fde_pkg::CH_DIS)
			begin
				n.ch[i].dis_req = 1'b1;
			end
			if (act[i])
			begin
				// activate cancels a pending disable or restarts a stopped channel
				n.ch[i].dis_req = 1'b0;
				if (n.ch[i].st == fde_pkg::CH_DIS)
				begin
					n.ch[i].st = fde_pkg::CH_UPD;
				end
			end
			// set wins over a same-cycle clear
			n.ch[i].null_evt = (s.ch[i].null_evt && !clr[i]) || set_evt[i];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			s <= '0;
			s.eng <= fde_pkg::E_IDLE;
			s.tokens <= fde_pkg::RST_TOKEN;
			for (int i = 0; i < 2; i++)
			begin
				s.ch[i].st <= fde_pkg::CH_DIS;
				s.ch[i].next_ptr <= fde_pkg::RST_PTR;
				s.ch[i].cur_ptr <= fde_pkg::RST_PTR;
				s.ch[i].sig_cnt <= fde_pkg::RST_CNT;
				s.ch[i].blk_cnt <= fde_pkg::RST_CNT;
				s.ch[i].frm_cnt <= fde_pkg::RST_CNT;
			end
		end
		else
		begin
			s <= n;
		end
	end

	assign hreadyout = s.hreadyout;
	assign hresp = 1'b0;
	assign hrdata = s.hrdata;
	assign mem = s.mem;
	assign xq_ready = s.xq_ready;
	assign iq_valid = s.iq_valid;
	assign iq_beat = s.iq;

endmodule : fde_engine

// ---- rtl/fde_pkg.sv ----
// shared constants, types and carriers for the frame dma engine
package fde_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// register byte offsets on the ahb-lite slave
	localparam logic [7:0] A_ACTIVATE = 8'h00;
	localparam logic [7:0] A_DISABLE = 8'h04;
	localparam logic [7:0] A_STATE = 8'h08;
	localparam logic [7:0] A_SAFE = 8'h0c;
	localparam logic [7:0] A_NULL_EVT = 8'h10;
	localparam logic [7:0] A_CFG = 8'h14;
	localparam logic [7:0] A_NEXT0 = 8'h18;
	localparam logic [7:0] A_NEXT1 = 8'h1c;
	localparam logic [7:0] A_CUR0 = 8'h20;
	localparam logic [7:0] A_CUR1 = 8'h24;
	localparam logic [7:0] A_CNT0 = 8'h28;
	localparam logic [7:0] A_CNT1 = 8'h2c;
	localparam logic [7:0] A_TOKEN = 8'h30;

	////////////////////////////////////////////////////////////////////////////////
	// control block field positions
	localparam int SZ_SIG = 16;
	localparam int SZ_TOKEN = 17;
	localparam int ST_SOF = 16;
	localparam int ST_EOF = 17;
	localparam int ST_ABORT = 18;
	localparam int ST_PD = 19;
	localparam int ST_OFS_LO = 20;
	localparam logic [31:0] STAT_OFS = 32'h0000000c;
	localparam logic [31:0] WORD_STEP = 32'h00000004;
	// config register: two bits per channel
	localparam int CFG_STOP_FRM = 0;
	localparam int CFG_STOP_BLK = 1;
	localparam int CFG_STRIDE = 2;

	////////////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [31:0] RST_PTR = 32'h00000000;
	localparam logic [7:0] RST_CNT = 8'h00;
	localparam logic [7:0] RST_TOKEN = 8'h00;

	////////////////////////////////////////////////////////////////////////////////
	// types
	typedef enum logic [1:0] {CH_DIS, CH_UPD, CH_ACT} fde_chst_t;

	// nine states need four bits
	typedef enum logic [3:0] {
		E_IDLE, E_LOAD, E_TOKEN, E_XTAKE, E_XWRITE, E_INEXT, E_IREAD, E_IPUSH, E_STATUS
	} fde_eng_t;

	// byte from the queuing system into an extraction buffer
	typedef struct packed {
		logic [7:0] data;
		logic sof;
		logic eof;
		logic abort;
		logic pruned;
	} fde_xbeat_t;

	// byte from an injection buffer to the queuing system
	typedef struct packed {
		logic [7:0] data;
		logic sof;
		logic eof;
		logic abort;
	} fde_ibeat_t;

	// system memory request
	typedef struct packed {
		logic req;
		logic we;
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [3:0] be;
	} fde_mem_t;

	typedef struct packed {
		fde_chst_t st;
		logic dis_req;
		logic null_evt;
		logic stop_frm;
		logic stop_blk;
		logic [31:0] next_ptr;
		logic [31:0] cur_ptr;
		logic [7:0] sig_cnt;
		logic [7:0] blk_cnt;
		logic [7:0] frm_cnt;
	} fde_chan_t;

endpackage : fde_pkg

// ---- tb/fde_engine_asserts.sv ----
// port assertions for the frame dma engine
`timescale 1ns/10ps
module fde_engine_asserts
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic [31:0] hrdata,
	input fde_pkg::fde_mem_t mem,
	input wire logic mem_ack,
	input wire logic xq_valid,
	input wire logic xq_ready,
	input wire logic iq_valid,
	input fde_pkg::fde_ibeat_t iq_beat,
	input wire logic iq_ready
);
	default clocking dc @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	ahb_ready_a: assert property ($past(hresetn) |-> hreadyout)
		else $error("hreadyout low after reset");
	rdata_hold_a: assert property (!(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
		else $error("hrdata moved without a read");
	mem_hold_a: assert property (mem.req && !mem_ack |=> mem.req && $stable(mem.addr))
		else $error("memory request dropped before ack");
	mem_align_a: assert property (mem.req |-> mem.addr[1:0] == 2'b00)
		else $error("unaligned memory address");
	byte_lane_a: assert property (mem.req && mem.we && mem.be != 4'hf |-> $onehot(mem.be)
		&& mem.wdata[7:0] == mem.wdata[15:8] && mem.wdata[7:0] == mem.wdata[31:24])
		else $error("bad byte write lanes");
	xq_take_a: assert property (xq_valid && xq_ready |=> !xq_ready)
		else $error("xq_ready held after a take");
	iq_hold_a: assert property (iq_valid && !iq_ready |=> iq_valid && $stable(iq_beat))
		else $error("injection beat changed while stalled");
	abort_eof_a: assert property (iq_valid && iq_beat.abort |-> iq_beat.eof)
		else $error("abort beat without eof");
endmodule : fde_engine_asserts

bind fde_engine fde_engine_asserts chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
	.mem(mem), .mem_ack(mem_ack), .xq_valid(xq_valid), .xq_ready(xq_ready),
	.iq_valid(iq_valid), .iq_beat(iq_beat), .iq_ready(iq_ready));

// ---- tb/fde_engine_tb.sv ----
// self-checking bench for the frame dma engine
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fails++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module fde_engine_tb;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic xq_valid = 1'b0;
	logic iq_ready = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [3:0] dly = 4'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout, hresp, mem_ack, xq_ready, iq_valid;
	logic [31:0] hrdata, mem_rdata, rd;
	fde_pkg::fde_mem_t mem;
	fde_pkg::fde_xbeat_t xq_beat = '0;
	fde_pkg::fde_ibeat_t iq_beat;
	fde_pkg::fde_ibeat_t ibeats[$];
	int fails = 0;
	int checks_done = 0;

	fde_engine dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .mem(mem), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata), .xq_valid(xq_valid), .xq_beat(xq_beat), .xq_ready(xq_ready),
		.iq_valid(iq_valid), .iq_beat(iq_beat), .iq_ready(iq_ready));
	fde_mem_model mem_u (.hclk(hclk), .mem(mem), .dly(dly), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata));

	always #5 hclk = ~hclk;
	// queue side stalls every other cycle
	always @(posedge hclk)
		iq_ready <= ~iq_ready;
	always @(negedge hclk)
		if ((iq_valid & iq_ready) === 1'b1)
			ibeats.push_back(iq_beat);

	////////////////////////////////////////
	task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge hclk iff hreadyout);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk iff hreadyout);
		rd = hrdata;
	endtask : ahb

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		ahb(a, 1'b0, 32'h0);
		`CHK(rd, e)
	endtask : rdchk

	task automatic wait_state(input logic [3:0] e);
		repeat (3) @(posedge hclk);
		repeat (100)
		begin
			ahb(fde_pkg::A_STATE, 1'b0, 32'h0);
			if (rd[3:0] === e)
				break;
		end
		`CHK(rd[3:0], e)
	endtask : wait_state

	task automatic xsend(input logic [7:0] d, input logic s, input logic e);
		xq_beat <= '{data: d, sof: s, eof: e, abort: 1'b0, pruned: 1'b0};
		xq_valid <= 1'b1;
		@(posedge hclk iff (xq_valid && xq_ready));
	endtask : xsend

	task automatic put(input logic [31:0] a, input logic [31:0] d);
		mem_u.words[a[10:2]] = d;
	endtask : put

	function automatic logic [31:0] word(input logic [31:0] a);
		return mem_u.words[a[10:2]];
	endfunction : word

	task automatic summarize;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : summarize

	////////////////////////////////////////
	initial
	begin
		// single-block chains and the two-block chain at 0x180, each ending in a null link
		put(32'h100, 32'h0);
		put(32'h104, 32'h400);
		put(32'h108, 32'hab010008);
		put(32'h10c, 32'h001c0000);
		put(32'h400, 32'h0);
		put(32'h404, 32'hdeadbeef);
		put(32'h200, 32'h0);
		put(32'h204, 32'h500);
		put(32'h208, 32'h00020008);
		put(32'h20c, 32'h00230003);
		put(32'h240, 32'h0);
		put(32'h244, 32'h500);
		put(32'h248, 32'h8);
		put(32'h24c, 32'h00070001);
		put(32'h500, 32'h44332211);
		put(32'h504, 32'h88776655);
		put(32'h180, 32'h1c0);
		put(32'h184, 32'h480);
		put(32'h188, 32'h4);
		put(32'h18c, 32'h0);
		put(32'h1c0, 32'h0);
		put(32'h1c4, 32'h4c0);
		put(32'h1c8, 32'h4);
		put(32'h1cc, 32'h0);
		put(32'h480, 32'h0);
		put(32'h4c0, 32'h0);
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rdchk(fde_pkg::A_STATE, 32'h0);
		rdchk(8'h3c, 32'h0);
		ahb(fde_pkg::A_NEXT0, 1'b1, 32'h100);
		ahb(fde_pkg::A_ACTIVATE, 1'b1, 32'h1);
		xsend(8'ha1, 1'b1, 1'b0);
		xsend(8'hb2, 1'b0, 1'b0);
		xsend(8'hc3, 1'b0, 1'b1);
		xq_valid <= 1'b0;
		xq_beat <= ~xq_beat;
		wait_state(4'h0);
		`CHK(word(32'h400), 32'hc3b2a100)
		`CHK(word(32'h404), 32'hdeadbeef)
		`CHK(word(32'h10c), 32'h00130003)
		`CHK(word(32'h108), 32'hab010008)
		rdchk(fde_pkg::A_CNT0, 32'h00010101);
		rdchk(fde_pkg::A_CUR0, 32'h100);
		rdchk(fde_pkg::A_NULL_EVT, 32'h1);
		ahb(fde_pkg::A_NULL_EVT, 1'b1, 32'h1);
		rdchk(fde_pkg::A_NULL_EVT, 32'h0);
		dly <= 4'h3;
		ahb(fde_pkg::A_NEXT1, 1'b1, 32'h200);
		ahb(fde_pkg::A_ACTIVATE, 1'b1, 32'h2);
		repeat (60) @(posedge hclk);
		`CHK(ibeats.size(), 0)
		ahb(fde_pkg::A_TOKEN, 1'b1, 32'h1);
		wait_state(4'h0);
		`CHK(ibeats.size(), 3)
		`CHK(ibeats[0], {8'h33, 3'b100})
		`CHK(ibeats[1], {8'h44, 3'b000})
		`CHK(ibeats[2], {8'h55, 3'b010})
		rdchk(fde_pkg::A_TOKEN, 32'h0);
		`CHK(word(32'h20c), 32'h002b0003)
		rdchk(fde_pkg::A_NULL_EVT, 32'h2);
		ibeats.delete();
		ahb(fde_pkg::A_NEXT1, 1'b1, 32'h240);
		ahb(fde_pkg::A_ACTIVATE, 1'b1, 32'h2);
		wait_state(4'h0);
		`CHK(ibeats.size(), 1)
		`CHK(ibeats[0][1:0], 2'b11)
		`CHK(word(32'h24c), 32'h000f0001)
		rdchk(fde_pkg::A_CNT1, 32'h00010200);
		// two-block chain: stop after block, then restart and drain under disable
		ahb(fde_pkg::A_NULL_EVT, 1'b1, 32'h3);
		ahb(fde_pkg::A_CFG, 1'b1, 32'h2);
		ahb(fde_pkg::A_NEXT0, 1'b1, 32'h180);
		ahb(fde_pkg::A_ACTIVATE, 1'b1, 32'h1);
		xsend(8'h5a, 1'b1, 1'b1);
		xq_valid <= 1'b0;
		wait_state(4'h0);
		`CHK(word(32'h18c), 32'h00030001)
		`CHK(word(32'h480), 32'h0000005a)
		rdchk(fde_pkg::A_NULL_EVT, 32'h1);
		rdchk(fde_pkg::A_NEXT0, 32'h1c0);
		rdchk(fde_pkg::A_CUR0, 32'h180);
		ahb(fde_pkg::A_CFG, 1'b1, 32'h0);
		ahb(fde_pkg::A_ACTIVATE, 1'b1, 32'h1);
		wait_state(4'h2);
		rdchk(fde_pkg::A_SAFE, 32'h2);
		ahb(fde_pkg::A_DISABLE, 1'b1, 32'h1);
		rdchk(fde_pkg::A_SAFE, 32'h3);
		ahb(fde_pkg::A_ACTIVATE, 1'b1, 32'h1);
		rdchk(fde_pkg::A_DISABLE, 32'h0);
		ahb(fde_pkg::A_DISABLE, 1'b1, 32'h1);
		rdchk(fde_pkg::A_DISABLE, 32'h1);
		xsend(8'h6b, 1'b1, 1'b1);
		xq_valid <= 1'b0;
		wait_state(4'h0);
		`CHK(word(32'h1cc), 32'h00030001)
		`CHK(word(32'h4c0), 32'h0000006b)
		rdchk(fde_pkg::A_DISABLE, 32'h0);
		rdchk(fde_pkg::A_CNT0, 32'h00030301);
		summarize();
	end

	initial
	begin
		#150000;
		fails++;
		summarize();
	end
endmodule : fde_engine_tb

// ---- tb/fde_mem_model.sv ----
// behavioural system memory answering the engine's word requests
`timescale 1ns/10ps
module fde_mem_model
(
	input wire logic hclk,
	input fde_pkg::fde_mem_t mem,
	input wire logic [3:0] dly,
	output logic mem_ack,
	output logic [31:0] mem_rdata
);
	// word array only: buffers and blocks sit on word boundaries
	logic [31:0] words [0:511];
	logic [3:0] wait_cnt;

	initial
	begin
		mem_ack = 1'b0;
		mem_rdata = 32'h0;
		wait_cnt = 4'h0;
	end

	////////////////////////////////////////
	always @(posedge hclk)
	begin
		mem_ack <= 1'b0;
		// idle read data keeps toggling so a stale word never passes for a fresh one
		mem_rdata <= ~mem_rdata;
		if (mem.req && !mem_ack)
		begin
			if (wait_cnt < dly)
				wait_cnt <= wait_cnt + 4'h1;
			else
			begin
				wait_cnt <= 4'h0;
				mem_ack <= 1'b1;
				if (mem.we)
				begin
					for (int i = 0; i < 4; i++)
						if (mem.be[i])
							words[mem.addr[10:2]][i*8 +: 8] <= mem.wdata[i*8 +: 8];
				end
				else
					mem_rdata <= words[mem.addr[10:2]];
			end
		end
	end
endmodule : fde_mem_model
